// ### include/sdpt_regs.svh
// constants for the sdram page tracking block
`ifndef SDPT_REGS_SVH
`define SDPT_REGS_SVH
`define SDPT_NUM_SPACES    4
`define SDPT_PAGE_W        14
`define SDPT_PAGE_HI       23
`define SDPT_PAGE_LO_W8    10
`define SDPT_PAGE_LO_W9    11
`define SDPT_SPACE_LO      24
`define SDPT_SPACE_HI      25
`define SDPT_ROW_LO_W8     10
`define SDPT_ROW_LO_W9     11
`define SDPT_COL_LO        2
`define SDPT_SPACE_MEMORY_TYPE_SDRAM   3'h3
`define SDPT_BOOT_SDRAM    5'h03
`define SDPT_INIT_WAIT     8'h10
`endif

// ### include/sdpt_pkg.sv
// types for the sdram page tracking block
`default_nettype none
package sdpt_pkg;
  typedef enum logic [2:0] {
    SDPT_CMD_NOP   = 3'h0,
    SDPT_CMD_DEAC  = 3'h1,
    SDPT_CMD_ACTV  = 3'h2,
    SDPT_CMD_READ  = 3'h3,
    SDPT_CMD_WRITE = 3'h4
  } sdpt_cmd_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } sdpt_req_t;
  typedef struct packed {
    sdpt_cmd_t   cmd;
    logic [3:0]  cs_sel;
    logic [13:0] addr;
    logic        sdram_a10_line;
  } sdpt_sdcmd_t;
endpackage
`default_nettype wire

// ### src/sdpt_page_cmp.sv
// one page register with its hit compare
`default_nettype none
`include "sdpt_regs.svh"
module sdpt_page_cmp
  import sdpt_pkg::*;
#(
  parameter int PAGE_W = `SDPT_PAGE_W
) (
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              enable_i,
  input  wire logic [PAGE_W-1:0] page_i,
  input  wire logic              load_i,
  input  wire logic              invalidate_i,
  output logic                   hit_o,
  output logic                   valid_o
);
  logic [PAGE_W-1:0] page_q, page_d;
  logic              valid_q, valid_d;

  always_comb begin
    page_d  = page_q;
    valid_d = valid_q;
    if (invalidate_i) begin
      valid_d = 1'b0; // RQ18
    end else if (load_i) begin
      page_d  = page_i;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      page_q  <= '0;
      valid_q <= 1'b0; // RQ18
    end else begin
      page_q  <= page_d;
      valid_q <= valid_d;
    end
  end

  // unused when the space is not sdram
  assign hit_o   = enable_i && valid_q && (page_q == page_i); // RQ8 RQ10
  assign valid_o = valid_q;
endmodule
`default_nettype wire

// ### src/sdpt_ctrl.sv
// sdram page tracking, boot init and command sequencing
// Summary of operation
// RQ1 - column width selectable as 8 or 9 bits
// RQ2 - row plus bank width is 14 bits for 8 columns, 13 for 9
// RQ3 - each space reaches at most 16M bytes; higher bits ignored
// RQ4 - boot straps selecting sdram for space zero run hardware init first
// RQ5 - deactivate during boot init waits until hold request drops
// RQ6 - external master under hold must not touch sdram banks
// RQ7 - four page registers, one per chip-select space
// RQ8 - page register used only when its space is typed sdram
// RQ9 - each space tracks its own single open page
// RQ10 - every access compares address against stored page
// RQ11 - width select zero compares address bits 23 to 11
// RQ12 - width select one compares address bits 23 to 10
// RQ13 - bits 25 and 24 select space and are not compared
// RQ14 - page miss in same space deactivates all banks then activates
// RQ15 - a10 line driven low on read and write commands
// RQ16 - width select alone steers row and column address shifting
// RQ17 - page hit issues read or write directly, page kept
// RQ18 - reset and deactivate invalidate affected page registers
`default_nettype none
`include "sdpt_regs.svh"
module sdpt_ctrl
  import sdpt_pkg::*;
#(
  parameter int NUM_SPACES = `SDPT_NUM_SPACES,
  parameter int PAGE_W     = `SDPT_PAGE_W
) (
  input  wire logic                  clock_i,
  input  wire logic                  srst_i,
  input  wire logic                  column_width_select_i,
  input  wire logic [NUM_SPACES-1:0][2:0] space_memory_type_i,
  input  wire logic [4:0]            boot_mode_i,
  input  wire logic                  hold_req_n_i,
  input  wire sdpt_req_t             req_i,
  output logic                       req_ready_o,
  output logic                       boot_done_o,
  output sdpt_sdcmd_t                sd_cmd_o,
  output logic [NUM_SPACES-1:0]      page_valid_o,
  output logic                       page_hit_o
);
  typedef enum logic [2:0] {
    SDPT_ST_STRAP = 3'b000,
    SDPT_ST_BWAIT = 3'b001,
    SDPT_ST_BDEAC = 3'b010,
    SDPT_ST_IDLE  = 3'b011,
    SDPT_ST_ACTV  = 3'b100,
    SDPT_ST_RW    = 3'b101
  } sdpt_state_t;

  sdpt_state_t       state_q, state_d;
  sdpt_req_t         hold_req_q, hold_req_d;
  sdpt_sdcmd_t       cmd_q, cmd_d;
  logic [7:0]        wait_q, wait_d;
  logic              done_q, done_d;

  logic [NUM_SPACES-1:0] space_is_sdram;
  logic [NUM_SPACES-1:0] hit_vec;
  logic [NUM_SPACES-1:0] valid_vec;
  logic [NUM_SPACES-1:0] load_vec;
  logic [NUM_SPACES-1:0] inval_vec;
  logic [PAGE_W-1:0]     req_page;
  logic [1:0]            req_space;
  logic                  req_hit;

  // page value from an address, 13 bits zero-extended for 9 columns
  function automatic logic [PAGE_W-1:0] page_of(input logic [31:0] a,
                                               input logic wsel);
    logic [PAGE_W-1:0] p;
    p = '0;
    if (wsel) begin
      p = a[`SDPT_PAGE_HI:`SDPT_PAGE_LO_W8]; // RQ12 RQ2
    end else begin
      p = {1'b0, a[`SDPT_PAGE_HI:`SDPT_PAGE_LO_W9]}; // RQ11 RQ2
    end
    return p;
  endfunction

  // row or column phase address; a10 pin carried separately
  function automatic logic [13:0] pin_addr(input logic [31:0] a,
                                          input logic wsel,
                                          input logic row);
    logic [13:0] r;
    r = '0;
    if (row && wsel) begin
      r = a[`SDPT_PAGE_HI:`SDPT_ROW_LO_W8]; // RQ16
    end else if (row) begin
      r = {1'b0, a[`SDPT_PAGE_HI:`SDPT_ROW_LO_W9]}; // RQ16
    end else if (wsel) begin
      // bank bits kept above, column below
      r = {a[23:21], 1'b0, a[19:18], a[9:`SDPT_COL_LO]}; // RQ16
    end else begin
      r = {1'b0, a[23:22], 1'b0, a[20], a[10:`SDPT_COL_LO]}; // RQ16
    end
    return r;
  endfunction

  // bits above 25 are ignored, so each space wraps at 16M bytes
  assign req_space = hold_req_q.addr[`SDPT_SPACE_HI:`SDPT_SPACE_LO]; // RQ13 RQ3
  assign req_page  = page_of(hold_req_q.addr, column_width_select_i); // RQ1

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SPACES; gi++) begin : g_page
      assign space_is_sdram[gi] =
        (space_memory_type_i[gi] == `SDPT_SPACE_MEMORY_TYPE_SDRAM); // RQ8
      sdpt_page_cmp #(
        .PAGE_W (PAGE_W)
      ) u_page (
        .clock_i      (clock_i),
        .srst_i       (srst_i),
        .enable_i     (space_is_sdram[gi]),
        .page_i       (req_page),
        .load_i       (load_vec[gi]),
        .invalidate_i (inval_vec[gi]),
        .hit_o        (hit_vec[gi]),
        .valid_o      (valid_vec[gi])
      ); // RQ7 RQ9
    end
  endgenerate

  assign req_hit = hit_vec[req_space]; // RQ10

  always_comb begin
    state_d    = state_q;
    hold_req_d = hold_req_q;
    cmd_d      = '{cmd: SDPT_CMD_NOP, cs_sel: '0, addr: '0,
                   sdram_a10_line: 1'b0};
    wait_d     = wait_q;
    done_d     = done_q;
    load_vec   = '0;
    inval_vec  = '0;
    case (state_q)
      SDPT_ST_STRAP: begin
        // straps caught one clock after reset release
        if (boot_mode_i == `SDPT_BOOT_SDRAM && space_is_sdram[0]) begin
          state_d = SDPT_ST_BWAIT; // RQ4
          wait_d  = `SDPT_INIT_WAIT;
        end else begin
          state_d = SDPT_ST_IDLE;
          done_d  = 1'b1;
        end
      end
      SDPT_ST_BWAIT: begin
        if (wait_q != 8'h00) begin
          wait_d = wait_q - 8'h01;
        end else begin
          state_d = SDPT_ST_BDEAC;
        end
      end
      SDPT_ST_BDEAC: begin
        // an external master owns the pins while hold is low
        if (hold_req_n_i) begin // RQ5 RQ6
          cmd_d.cmd            = SDPT_CMD_DEAC;
          cmd_d.cs_sel         = space_is_sdram;
          cmd_d.sdram_a10_line = 1'b1;
          inval_vec            = '1; // RQ18
          state_d              = SDPT_ST_IDLE;
          done_d               = 1'b1; // RQ4
        end
      end
      SDPT_ST_IDLE: begin
        if (req_i.valid) begin
          hold_req_d = req_i;
          state_d    = SDPT_ST_ACTV;
        end
      end
      SDPT_ST_ACTV: begin
        if (!space_is_sdram[req_space]) begin
          state_d = SDPT_ST_IDLE;
        end else if (req_hit) begin
          // open page: straight to column command
          cmd_d.cmd    = hold_req_q.write ? SDPT_CMD_WRITE
                                          : SDPT_CMD_READ; // RQ17
          cmd_d.cs_sel = 4'h1 << req_space;
          cmd_d.addr   = pin_addr(hold_req_q.addr, column_width_select_i,
                                  1'b0);
          cmd_d.sdram_a10_line = 1'b0; // RQ15
          state_d      = SDPT_ST_IDLE;
        end else if (valid_vec[req_space]) begin
          cmd_d.cmd            = SDPT_CMD_DEAC; // RQ14
          cmd_d.cs_sel         = space_is_sdram;
          cmd_d.sdram_a10_line = 1'b1;
          inval_vec            = '1; // RQ18
        end else begin
          cmd_d.cmd    = SDPT_CMD_ACTV; // RQ14
          cmd_d.cs_sel = 4'h1 << req_space;
          cmd_d.addr   = pin_addr(hold_req_q.addr, column_width_select_i,
                                  1'b1);
          cmd_d.sdram_a10_line = column_width_select_i ?
                                 hold_req_q.addr[20] : hold_req_q.addr[21];
          load_vec[req_space] = 1'b1;
          state_d      = SDPT_ST_RW;
        end
      end
      SDPT_ST_RW: begin
        cmd_d.cmd    = hold_req_q.write ? SDPT_CMD_WRITE : SDPT_CMD_READ;
        cmd_d.cs_sel = 4'h1 << req_space;
        cmd_d.addr   = pin_addr(hold_req_q.addr, column_width_select_i,
                                1'b0);
        cmd_d.sdram_a10_line = 1'b0; // RQ15
        state_d      = SDPT_ST_IDLE;
      end
      default: begin
        state_d = SDPT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q    <= SDPT_ST_STRAP;
      hold_req_q <= '0;
      cmd_q      <= '0;
      wait_q     <= 8'h00;
      done_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      hold_req_q <= hold_req_d;
      cmd_q      <= cmd_d;
      wait_q     <= wait_d;
      done_q     <= done_d;
    end
  end

  assign req_ready_o  = (state_q == SDPT_ST_IDLE);
  assign boot_done_o  = done_q;
  assign sd_cmd_o     = cmd_q;
  assign page_valid_o = valid_vec;
  assign page_hit_o   = (state_q == SDPT_ST_ACTV) && req_hit;
endmodule
`default_nettype wire

// ### tb/sdpt_ctrl_checker.sv
// assertions and covers on the page tracking control ports
`default_nettype none
module sdpt_ctrl_checker
  import sdpt_pkg::*;
#(
  parameter int NUM_SPACES = 4,
  parameter int PAGE_W     = 14
) (
  input wire logic                       clock_i,
  input wire logic                       srst_i,
  input wire logic                       column_width_select_i,
  input wire logic [NUM_SPACES-1:0][2:0] space_memory_type_i,
  input wire logic [4:0]                 boot_mode_i,
  input wire logic                       hold_req_n_i,
  input wire sdpt_req_t                  req_i,
  input wire logic                       req_ready_o,
  input wire logic                       boot_done_o,
  input wire sdpt_sdcmd_t                sd_cmd_o,
  input wire logic [NUM_SPACES-1:0]      page_valid_o,
  input wire logic                       page_hit_o
);
  logic take, take_sd, rw, deac;
  assign take    = req_ready_o && req_i.valid;
  assign take_sd = take && space_memory_type_i[req_i.addr[25:24]] == 3'h3;
  assign rw      = sd_cmd_o.cmd inside {SDPT_CMD_READ, SDPT_CMD_WRITE};
  assign deac    = sd_cmd_o.cmd == SDPT_CMD_DEAC;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  AST_A10: assert property (rw |-> !sd_cmd_o.sdram_a10_line)
    else $error("a10 high on access");
  AST_HIT: assert property (page_hit_o |=> rw)
    else $error("hit without access");
  AST_MISS: assert property ($past(take_sd) && !page_hit_o |=>
    sd_cmd_o.cmd inside {SDPT_CMD_DEAC, SDPT_CMD_ACTV})
    else $error("miss without open");
  AST_DEAC: assert property ($past(boot_done_o) && deac |=>
    sd_cmd_o.cmd == SDPT_CMD_ACTV ##1 rw) else $error("no reopen");
  AST_INV: assert property (deac |-> ##[0:1] page_valid_o == '0)
    else $error("page kept open");
  AST_RST: assert property (disable iff (1'b0) srst_i |=>
    !req_ready_o && page_valid_o == '0 && sd_cmd_o.cmd == SDPT_CMD_NOP)
    else $error("bad reset state");
  AST_NOSD: assert property (take && !take_sd |=>
    (sd_cmd_o.cmd == SDPT_CMD_NOP) [*3]) else $error("cmd to other type");
  AST_HOLD: assert property (!hold_req_n_i && !boot_done_o |-> !deac)
    else $error("deac under hold");
  cover property (page_hit_o);
  cover property (deac && !boot_done_o);
  cover property (take && !take_sd);
endmodule
bind sdpt_ctrl sdpt_ctrl_checker #(
  .NUM_SPACES(NUM_SPACES),
  .PAGE_W(PAGE_W)
) u_sdpt_ctrl_checker (
  .clock_i(clock_i), .srst_i(srst_i),
  .column_width_select_i(column_width_select_i),
  .space_memory_type_i(space_memory_type_i), .boot_mode_i(boot_mode_i),
  .hold_req_n_i(hold_req_n_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .boot_done_o(boot_done_o), .sd_cmd_o(sd_cmd_o),
  .page_valid_o(page_valid_o), .page_hit_o(page_hit_o));
`default_nettype wire

// ### tb/sdpt_sdram_model.sv
// sdram device model that flags access to a closed bank
`default_nettype none
module sdpt_sdram_model
  import sdpt_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire sdpt_sdcmd_t cmd_i,
  output logic [7:0]       bad_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] open_q;
  always @(posedge clock_i) begin
    if (srst_i) begin
      open_q <= 4'h0;
      bad_o  <= 8'h00;
    end else begin
      case (cmd_i.cmd)
        SDPT_CMD_ACTV: open_q <= open_q | cmd_i.cs_sel;
        SDPT_CMD_DEAC: open_q <= open_q & ~cmd_i.cs_sel;
        SDPT_CMD_READ, SDPT_CMD_WRITE: begin
          // an a10 high here would close the row behind our back
          if ((cmd_i.cs_sel & ~open_q) != 4'h0 || cmd_i.sdram_a10_line)
            bad_o <= bad_o + 8'h01;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/sdpt_ctrl_bench.sv
// self-checking bench for the sdram page tracking control
`default_nettype none
module sdpt_ctrl_bench
  import sdpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic            clk = 1'h0, rst = 1'h1, wsel = 1'h0, hold_n = 1'h0;
  logic [3:0][2:0] space_memory_type = '0;
  logic [4:0]      boot = 5'h00;
  sdpt_req_t       req = '0;
  logic            ready, done, hit;
  sdpt_sdcmd_t     cmd;
  logic [3:0]      pvalid, vld;
  logic [7:0]      bad;
  logic [31:0]     seed = 32'h00000023, r;
  int              fails = 0, samples_checked = 0, pg[4], nhit = 0;
  sdpt_cmd_t       obs[$], expq[$];
  sdpt_ctrl u_sdpt_ctrl (.clock_i(clk), .srst_i(rst),
    .column_width_select_i(wsel), .space_memory_type_i(space_memory_type),
    .boot_mode_i(boot), .hold_req_n_i(hold_n), .req_i(req),
    .req_ready_o(ready), .boot_done_o(done), .sd_cmd_o(cmd),
    .page_valid_o(pvalid), .page_hit_o(hit));
  sdpt_sdram_model u_mem (.clock_i(clk), .srst_i(rst), .cmd_i(cmd),
    .bad_o(bad));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (!rst && cmd.cmd !== SDPT_CMD_NOP) obs.push_back(cmd.cmd);
    if (!rst && hit === 1'b1) nhit++;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic access(input logic [31:0] a, input logic w);
    int s, p;
    logic eh;
    s = a[25:24];
    p = wsel ? a[23:10] : a[23:11];
    eh = (space_memory_type[s] == 3'h3) && vld[s] && (pg[s] == p);
    if (space_memory_type[s] == 3'h3) begin
      if (!vld[s] || pg[s] != p) begin
        if (vld[s]) expq.push_back(SDPT_CMD_DEAC);
        if (vld[s]) vld = 4'h0;
        expq.push_back(SDPT_CMD_ACTV);
      end
      expq.push_back(w ? SDPT_CMD_WRITE : SDPT_CMD_READ);
      vld[s] = 1'b1;
      pg[s] = p;
    end
    wait_ready();
    @(posedge clk);
    req <= '{1'b1, w, a};
    @(posedge clk);
    req.valid <= 1'b0;
    repeat (3) @(negedge clk);
    wait_ready();
    repeat (2) @(negedge clk);
    chk("cmd count", expq.size(), obs.size());
    while (expq.size() > 0 && obs.size() > 0)
      chk("cmd", expq.pop_front(), obs.pop_front());
    expq.delete();
    obs.delete();
    chk("open pages", vld, pvalid);
    chk("page hit", eh, nhit);
    nhit = 0;
  endtask
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clk);
      rst <= 1'b1;
      wsel <= ph[0];
      boot <= ph ? 5'h00 : 5'h03;
      hold_n <= 1'b0;
      space_memory_type <= {3'h1, 3'h3, 3'h3, 3'h3};
      vld = 4'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (40) @(negedge clk);
      chk("pages after reset", 0, pvalid);
      chk("boot done", ph, done);
      @(posedge clk);
      hold_n <= 1'b1;
      wait_ready();
      // the deactivate lands in the queue one edge after ready rises
      repeat (2) @(negedge clk);
      chk("boot deac", ph ? 0 : 1, obs.size());
      obs.delete();
      repeat (60) begin
        r = xs();
        access(r & 32'hff800fff, r[1]);
      end
      chk("bank misuse", 0, bad);
    end
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
